// [core/board_watchdog_timer.sv]
// Board watchdog: control register, timeout counter and reset/interrupt outputs.
// Assumes the I/O strobes and the interrupt route bit come from logic on clk,
// and that rstn is the power-on reset only, never the watchdog's own hard reset.
// Function
// RL1 - One watchdog, timeout selectable from 125 ms up to 256 s.
// RL2 - Missed strobe while enabled gives reset, NMI or interrupt per configuration.
// RL3 - NMI versus interrupt delivery comes from the board interrupt register at 0x289.
// RL4 - Two-bit mode field selects timer-only, reset, interrupt or dual stage.
// RL5 - Disabled after power-on; no counting until software enables.
// RL6 - Software sets mode and period first, enable afterwards.
// RL7 - Once enabled, disable and mode changes are ignored until power cycle.
// RL8 - Writing one to retrigger restarts the period; software must do it in time.
// RL9 - Expiry sets the timeout flag in every mode.
// RL10 - Timer-only: software polls, clears flag by writing one, then retriggers.
// RL11 - Flag holds until software clears it or power cycles.
// RL12 - Reset mode: expiry asserts hard system reset.
// RL13 - The watchdog hard reset does not clear the flag.
// RL14 - Interrupt mode: expiry raises interrupt and sets flag, no reset.
// RL15 - Dual stage: first expiry raises interrupt and restarts the period.
// RL16 - Dual stage: second expiry without retrigger gives hard reset.
// RL17 - Timer-only expiry drives no reset or interrupt, only the flag.
// RL18 - Mode and period encodings follow the chosen register layout.
`timescale 1ns/1ps
`default_nettype none
module board_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES  = TICK_CYCLES_DFLT,
  parameter int RESET_CYCLES = HARD_RESET_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [11:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        nmi_route,
  output logic             hard_reset,
  output logic             nmi,
  output logic             irq
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  ctrl_s ctrl;
  ctrl_s next_ctrl;
  ctrl_s wd;
  logic  wr_hit;
  logic  rd_hit;
  logic  retrigger;
  logic  flag_clear;
  logic  timeout;
  logic  [7:0] next_rdata;

  assign wd         = ctrl_s'(io_wdata);
  assign wr_hit     = io_wr && (io_addr == WDT_CTRL_ADDR);
  assign rd_hit     = io_rd && (io_addr == WDT_CTRL_ADDR);
  assign retrigger  = wr_hit && wd.retrigger_strobe_bit && ctrl.enable;  // see RL8
  assign flag_clear = wr_hit && wd.timeout_status_flag;                  // see RL10

  always_comb begin
    next_ctrl = ctrl;
    next_ctrl.retrigger_strobe_bit = 1'b0;
    if (wr_hit) begin
      next_ctrl.period = wd.period;  // see RL1
      // Enable and mode freeze once enabled
      if (!ctrl.enable) begin  // see RL7
        next_ctrl.enable              = wd.enable;
        next_ctrl.timeout_mode_select = wd.timeout_mode_select;  // see RL4
      end
    end
    // Expiry in the same cycle as a clear keeps the flag set
    next_ctrl.timeout_status_flag = timeout || (ctrl.timeout_status_flag && !flag_clear);  // see RL9, see RL11
    next_rdata = rd_hit ? 8'(ctrl) : 8'h00;
  end

  // Only power-on reset reaches here, so the flag survives a watchdog reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= ctrl_s'(CTRL_RESET);  // see RL5, see RL13
      io_rdata <= 8'h00;
    end else begin
      ctrl     <= next_ctrl;
      io_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Timeout counter
  // ****************************************
  wdt_state_e              state;
  wdt_state_e              next_state;
  logic [PERIOD_CNT_W-1:0] count;
  logic [PERIOD_CNT_W-1:0] next_count;
  logic                    tick;
  logic                    restart;
  logic                    expire;
  logic                    irq_evt;
  logic                    rst_evt;

  assign expire  = tick && (count == 12'h0001);
  assign restart = retrigger || (state == ST_IDLE);

  wdt_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (restart),
    .tick    (tick)
  );

  always_comb begin
    next_state = state;
    next_count = count;
    timeout    = 1'b0;
    irq_evt    = 1'b0;
    rst_evt    = 1'b0;
    case (state)
      ST_IDLE: begin
        next_count = period_ticks(ctrl.period);  // see RL18
        if (ctrl.enable) begin  // see RL5
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (retrigger) begin
          next_count = period_ticks(ctrl.period);  // see RL8
        end else if (expire) begin
          timeout = 1'b1;  // see RL2
          case (ctrl.timeout_mode_select)
            MODE_RESET: begin
              rst_evt    = 1'b1;  // see RL12
              next_state = ST_EXPIRED;
            end
            MODE_IRQ: begin
              irq_evt    = 1'b1;  // see RL14
              next_state = ST_EXPIRED;
            end
            MODE_DUAL: begin
              irq_evt    = 1'b1;  // see RL15
              next_count = period_ticks(ctrl.period);
              next_state = ST_STAGE2;
            end
            default: begin
              next_state = ST_EXPIRED;  // see RL17
            end
          endcase
        end else if (tick) begin
          next_count = count - 1'b1;
        end
      end
      ST_STAGE2: begin
        if (retrigger) begin
          next_count = period_ticks(ctrl.period);  // see RL16
          next_state = ST_RUN;
        end else if (expire) begin
          timeout    = 1'b1;
          rst_evt    = 1'b1;  // see RL16
          next_state = ST_EXPIRED;
        end else if (tick) begin
          next_count = count - 1'b1;
        end
      end
      ST_EXPIRED: begin
        // Stays expired until software retriggers
        if (retrigger) begin
          next_count = period_ticks(ctrl.period);  // see RL10
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic        irq_pend;
  logic        next_irq_pend;
  logic [15:0] rst_cnt;
  logic [15:0] next_rst_cnt;
  logic        next_hard_reset;
  logic        next_nmi;
  logic        next_irq;

  always_comb begin
    next_irq_pend   = irq_evt || (irq_pend && !flag_clear);
    next_rst_cnt    = rst_evt ? 16'(RESET_CYCLES) : ((rst_cnt != 16'h0000) ? rst_cnt - 1'b1 : rst_cnt);
    next_hard_reset = (next_rst_cnt != 16'h0000);
    next_nmi        = next_irq_pend && nmi_route;   // see RL3
    next_irq        = next_irq_pend && !nmi_route;  // see RL3
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend   <= 1'b0;
      rst_cnt    <= 16'h0000;
      hard_reset <= 1'b0;
      nmi        <= 1'b0;
      irq        <= 1'b0;
    end else begin
      irq_pend   <= next_irq_pend;
      rst_cnt    <= next_rst_cnt;
      hard_reset <= next_hard_reset;
      nmi        <= next_nmi;
      irq        <= next_irq;
    end
  end

endmodule
`default_nettype wire

// [core/wdt_pkg.sv]
// Constants, register layout and types of the board watchdog.
// Assumes a 200 MHz board clock and an 8-bit I/O register port.
package wdt_pkg;

  // ****************************************
  // Register map and layout
  // ****************************************
  localparam logic [11:0] WDT_CTRL_ADDR  = 12'h0282;
  localparam logic [11:0] BOARD_IRQ_ADDR = 12'h0289;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          FLAG_BIT       = 7;
  localparam int          RETRIG_BIT     = 6;
  localparam int          ENABLE_BIT     = 5;
  localparam int          MODE_LSB       = 3;
  localparam int          PERIOD_LSB     = 0;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_RESET = 2'b01,
    MODE_DUAL  = 2'b10,
    MODE_IRQ   = 2'b11
  } mode_e;

  typedef struct packed {
    logic        timeout_status_flag;
    logic        retrigger_strobe_bit;
    logic        enable;
    mode_e       timeout_mode_select;
    logic [2:0]  period;
  } ctrl_s;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RUN     = 2'b01,
    ST_STAGE2  = 2'b11,
    ST_EXPIRED = 2'b10
  } wdt_state_e;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ             = 200_000_000;
  localparam int CLK_PERIOD_NS      = 5;
  localparam int MIN_TIMEOUT_MS     = 125;
  localparam int MAX_TIMEOUT_MS     = 256_000;
  localparam int TICK_CYCLES_DFLT   = (CLK_HZ / 1000) * MIN_TIMEOUT_MS;
  localparam int MAX_TICKS          = MAX_TIMEOUT_MS / MIN_TIMEOUT_MS;
  localparam int HARD_RESET_NS      = 1000;
  localparam int HARD_RESET_CYCLES  = (HARD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W         = 25;
  localparam int PERIOD_CNT_W       = 12;

  // Timeout in 125 ms ticks for each period code
  function automatic logic [PERIOD_CNT_W-1:0] period_ticks(input logic [2:0] code);
    case (code)
      3'd0:    period_ticks = 12'h0001;
      3'd1:    period_ticks = 12'h0002;
      3'd2:    period_ticks = 12'h0004;
      3'd3:    period_ticks = 12'h0008;
      3'd4:    period_ticks = 12'h0010;
      3'd5:    period_ticks = 12'h0040;
      3'd6:    period_ticks = 12'h0200;
      default: period_ticks = PERIOD_CNT_W'(MAX_TICKS);
    endcase
  endfunction

endpackage

// [core/wdt_tick.sv]
// Prescaler giving one pulse per minimum timeout interval.
// Assumes an asynchronously asserted, synchronously released reset from the parent.
`timescale 1ns/1ps
`default_nettype none
module wdt_tick
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);

  logic [TICK_CNT_W-1:0] cnt;
  logic [TICK_CNT_W-1:0] next_cnt;
  logic                  next_tick;

  // Restart realigns the prescaler so a retrigger gives a full period
  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 1'b1;
    if (restart) begin
      next_cnt = '0;
    end else if (cnt == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule
`default_nettype wire

// [verification/wdt_properties.sv]
// Port checker of the board watchdog.
// Assumes binding to board_watchdog_timer; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module wdt_properties
  import wdt_pkg::*;
#(
  parameter int RESET_CYCLES = HARD_RESET_CYCLES
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [11:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        nmi_route,
  input wire logic        hard_reset,
  input wire logic        nmi,
  input wire logic        irq
);
  // ****
  // Helpers
  // ****
  logic       en_q;
  logic [1:0] mode_q;
  int         hr_cnt;
  wire logic  hit_wr = io_wr && io_addr == WDT_CTRL_ADDR;
  wire logic  hit_rd = io_rd && io_addr == WDT_CTRL_ADDR;
  // Mode is captured once, at the enabling write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q   <= 1'b0;
      mode_q <= 2'b00;
      hr_cnt <= 0;
    end else begin
      if (hit_wr && !en_q && io_wdata[ENABLE_BIT]) begin
        en_q   <= 1'b1;
        mode_q <= io_wdata[4:3];
      end
      hr_cnt <= hard_reset ? hr_cnt + 1 : 0;
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!hit_rd |=> io_rdata == 8'h00)
    else $error("read data not idle");
  a_retrig_reads_zero: assert property (hit_rd |=> !io_rdata[RETRIG_BIT])
    else $error("retrigger bit read as one");
  a_off_silent: assert property (!en_q |-> !(hard_reset || irq || nmi))
    else $error("output while disabled");
  a_mode_locked: assert property (hit_rd && en_q |=> io_rdata[ENABLE_BIT] && io_rdata[4:3] == mode_q)
    else $error("enable or mode changed");
  a_timer_quiet: assert property (en_q && mode_q == MODE_TIMER |-> !(hard_reset || irq || nmi))
    else $error("timer mode drove an output");
  a_reset_no_irq: assert property (en_q && mode_q == MODE_RESET |-> !(irq || nmi))
    else $error("interrupt in reset mode");
  a_irq_no_reset: assert property (en_q && mode_q == MODE_IRQ |-> !hard_reset)
    else $error("hard reset in interrupt mode");
  a_route_irq: assert property (irq |-> !$past(nmi_route) && !nmi)
    else $error("maskable interrupt on nmi route");
  a_route_nmi: assert property (nmi |-> $past(nmi_route))
    else $error("nmi on maskable route");
  a_reset_len: assert property ($fell(hard_reset) |-> hr_cnt == RESET_CYCLES)
    else $error("hard reset length wrong");
  a_irq_clear: assert property (hit_wr && io_wdata[FLAG_BIT] && mode_q == MODE_IRQ |=> !irq)
    else $error("interrupt not cleared");
endmodule
bind board_watchdog_timer wdt_properties #(.RESET_CYCLES(RESET_CYCLES)) u_props (.clk, .rstn,
  .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .nmi_route, .hard_reset, .nmi, .irq);
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench of the board watchdog, one power cycle per mode.
// Assumes one-cycle I/O strobes on clk and a short prescaler.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wdt_pkg::*;
;
  localparam int TICKS   = 4;
  localparam int RST_CYC = 8;
  logic        clk, rstn, io_wr, io_rd, nmi_route, hard_reset, nmi, irq;
  logic [11:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, got, e;
  logic [15:0] lfsr = 16'h1bdf;
  int          failures, n_checks, hr_len;

  board_watchdog_timer #(.TICK_CYCLES(TICKS), .RESET_CYCLES(RST_CYC)) dut (.clk, .rstn, .io_addr,
    .io_wr, .io_rd, .io_wdata, .io_rdata, .nmi_route, .hard_reset, .nmi, .irq);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (hard_reset === 1'b1) hr_len++;

  // ****
  // Tasks
  // ****
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk); io_wr <= 1'b1; io_addr <= a; io_wdata <= d;
    @(posedge clk); io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk); io_rd <= 1'b1; io_addr <= a;
    @(posedge clk); io_rd <= 1'b0;
    #1 got = io_rdata;
  endtask
  // Bounded: flag up, no reset running, dual stage needs its reset seen
  task automatic wait_done(input int m);
    for (int i = 0; i <= 40; i++) begin
      rd(WDT_CTRL_ADDR);
      if (got[FLAG_BIT] && !hard_reset && (m != 2 || hr_len > 0)) break;
      if (i == 40) begin
        failures++;
        report_and_stop();
      end
    end
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    rstn = 1'b0; io_wr = 1'b0; io_rd = 1'b0; io_addr = 12'h000; io_wdata = 8'h00; nmi_route = 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      rstn <= 1'b0;
      nmi_route <= (m == 2);
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      hr_len = 0;
      rd(WDT_CTRL_ADDR); check(got, CTRL_RESET);
      lfsr = next_rand(lfsr);
      wr(BOARD_IRQ_ADDR + lfsr[3:0], lfsr[15:8]);
      rd(BOARD_IRQ_ADDR + lfsr[3:0]); check(got, 8'h00);
      e = 8'h20 | 8'(m << 3) | {7'h00, lfsr[4]};
      wr(WDT_CTRL_ADDR, e);
      repeat (10) wr(WDT_CTRL_ADDR, e | 8'h40);
      rd(WDT_CTRL_ADDR); check(got, e);
      check(8'(hr_len), 8'h00);
      wr(WDT_CTRL_ADDR, {5'h00, ~m[1:0], 3'h0});
      e = 8'h20 | 8'(m << 3);
      wait_done(m);
      check(got, e | 8'h80);
      check(8'(hr_len), 8'((m == 1 || m == 2) ? RST_CYC : 0));
      check({7'h00, irq}, {7'h00, m == 3});
      check({7'h00, nmi}, {7'h00, m == 2});
      repeat (20) @(posedge clk);
      rd(WDT_CTRL_ADDR); check(got, e | 8'h80);
      wr(WDT_CTRL_ADDR, e | 8'h80);
      rd(WDT_CTRL_ADDR); check(got, e);
      check({6'h00, irq, nmi}, 8'h00);
      hr_len = 0;
      wr(WDT_CTRL_ADDR, e | 8'h40);
      wait_done(m);
      check(got, e | 8'h80);
      // Dual stage, retrigger between the two expiries: no hard reset
      if (m == 2) begin
        hr_len = 0;
        wr(WDT_CTRL_ADDR, 8'hb3);
        wr(WDT_CTRL_ADDR, 8'h73);
        wait_done(0);
        check(got, 8'hb3);
        wr(WDT_CTRL_ADDR, 8'h73);
        repeat (40) @(posedge clk);
        check(8'(hr_len), 8'h00);
        check({7'h00, nmi}, 8'h01);
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
